// file: hw/lamp_pkg.sv
// constants for the communication card status lamp driver
// assumes one 125 MHz card clock and a plain register port
package lamp_pkg;
   // ***************************************************
   // clock and lamp timing
   // ***************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned LINK_HALF_MS = 500;
   localparam int unsigned FAST_HALF_MS = 200;
   localparam int unsigned FLASH_ON_MS = 200;
   localparam int unsigned FLASH_OFF_MS = 1000;
   localparam int unsigned LINK_HALF_CYC = LINK_HALF_MS * CYC_PER_MS;
   localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
   localparam int unsigned FLASH_ON_CYC = FLASH_ON_MS * CYC_PER_MS;
   localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CYC_PER_MS;
   localparam int CNT_W = 28;

   // ***************************************************
   // input encodings
   // ***************************************************
   localparam logic [1:0] LINK_DOWN = 2'h0;
   localparam logic [1:0] LINK_OPENING = 2'h1;
   localparam logic [1:0] LINK_UP = 2'h2;
   localparam logic [1:0] NODE_OPER = 2'h0;
   localparam logic [1:0] NODE_PREOP = 2'h1;
   localparam logic [1:0] NODE_STOP = 2'h2;
   localparam logic [1:0] STACK_IDLE = 2'h0;
   localparam logic [1:0] STACK_WAIT = 2'h1;
   localparam logic [1:0] STACK_RUN = 2'h2;

   // ***************************************************
   // register map
   // ***************************************************
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int PORTS = 2;
   localparam int EVT_W = 4;
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_EVT_STAT = 8'h04;
   localparam logic [AW-1:0] OFS_EVT_CLR = 8'h08;
   localparam logic [AW-1:0] OFS_EVT_EN = 8'h0C;
   localparam logic [AW-1:0] OFS_LAMPS = 8'h10;
   localparam int CTRL_TEST_BIT = 0;
   localparam int EVT_RX_ERR = 0;
   localparam int EVT_BUS_OFF = 1;
   localparam int EVT_LINK_LOST = 2;
   localparam int EVT_PORT_CHG = 3;
   localparam int LAMPS_W = 9;
endpackage : lamp_pkg

// file: hw/status_lamp_driver.sv
// status lamp driver for the fieldbus communication cards
// assumes status inputs on mclk, port link/traffic inputs from pins
// Function
// - card lamp lit while connecting
// - card lamp 1 s blink once connected
// - card lamp dark when disconnected
// - run lamp lit when operational
// - run lamp dark on fault
// - run lamp blinks in pre-operational
// - run lamp single flash when stopped
// - error lamp lit on bus-off or drive fault
// - error lamp dark with no error
// - error lamp blinks on bad address
// - error lamp flashes on receive error
// - bus lamp lit without link, blinks linked
// - bus lamp dark once communicating
// - ready lamp on, blinking, or off
// - port link lamp follows cable link
// - port traffic lamp follows data exchange
`timescale 1ns/1ps
module status_lamp_driver #(
   parameter int unsigned LINK_HALF_CYC = lamp_pkg::LINK_HALF_CYC,
   parameter int unsigned FAST_HALF_CYC = lamp_pkg::FAST_HALF_CYC,
   parameter int unsigned FLASH_ON_CYC = lamp_pkg::FLASH_ON_CYC,
   parameter int unsigned FLASH_OFF_CYC = lamp_pkg::FLASH_OFF_CYC
)(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [lamp_pkg::AW-1:0] addr,
   input wire logic [lamp_pkg::DW-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [lamp_pkg::DW-1:0] rd_data,
   output logic irq,
   input wire logic [1:0] card_link_state,
   input wire logic [1:0] node_state,
   input wire logic node_fault,
   input wire logic bus_off,
   input wire logic drive_fault,
   input wire logic addr_invalid,
   input wire logic rx_error,
   input wire logic net_link,
   input wire logic net_comm_up,
   input wire logic [1:0] stack_state,
   input wire logic [lamp_pkg::PORTS-1:0] port_link,
   input wire logic [lamp_pkg::PORTS-1:0] port_traffic,
   output logic card_link_lamp,
   output logic node_run_lamp,
   output logic node_error_lamp,
   output logic bus_state_lamp,
   output logic stack_ready_lamp,
   output logic [lamp_pkg::PORTS-1:0] port_link_lamp,
   output logic [lamp_pkg::PORTS-1:0] port_traffic_lamp
);
   localparam int NP = lamp_pkg::PORTS;
   localparam int CW = lamp_pkg::CNT_W;
   localparam logic [CW-1:0] LINK_LAST = CW'(LINK_HALF_CYC - 1);
   localparam logic [CW-1:0] FAST_LAST = CW'(FAST_HALF_CYC - 1);
   localparam logic [CW-1:0] FLASH_ON = CW'(FLASH_ON_CYC);
   localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_ON_CYC + FLASH_OFF_CYC - 1);

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic [2*NP-1:0] pin_raw;
   logic [2*NP-1:0] s1_q;
   logic [2*NP-1:0] s2_q;
   logic [2*NP-1:0] s3_q;
   logic [2*NP-1:0] pin_q;
   assign pin_raw = {port_traffic, port_link};

   genvar gi;
   generate
      for (gi = 0; gi < 2 * NP; gi++)
      begin : g_sync
         always_ff @(posedge mclk)
         begin
            if (!rst_b)
            begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
            end
            else
            begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
               begin
                  pin_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   // ***************************************************
   // blink and flash timebases
   // ***************************************************
   logic [CW-1:0] link_cnt_q;
   logic link_phase_q;
   logic [CW-1:0] fast_cnt_q;
   logic fast_phase_q;
   logic [CW-1:0] flash_cnt_q;
   logic flash_lit;
   logic flash_wrap;
   assign flash_lit = (flash_cnt_q < FLASH_ON);
   assign flash_wrap = (flash_cnt_q == FLASH_LAST);

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         link_cnt_q <= '0;
         link_phase_q <= 1'b1;
      end
      else if (link_cnt_q == LINK_LAST)
      begin
         link_cnt_q <= '0;
         link_phase_q <= ~link_phase_q;
      end
      else
      begin
         link_cnt_q <= link_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         fast_cnt_q <= '0;
         fast_phase_q <= 1'b1;
      end
      else if (fast_cnt_q == FAST_LAST)
      begin
         fast_cnt_q <= '0;
         fast_phase_q <= ~fast_phase_q;
      end
      else
      begin
         fast_cnt_q <= fast_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b || flash_wrap)
      begin
         flash_cnt_q <= '0;
      end
      else
      begin
         flash_cnt_q <= flash_cnt_q + 1'b1;
      end
   end

   // ***************************************************
   // receive error one-shot flash
   // ***************************************************
   logic rx_flash_q;
   logic rx_seen_q;
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rx_flash_q <= 1'b0;
         rx_seen_q <= 1'b0;
      end
      else if (rx_error)
      begin
         rx_flash_q <= 1'b1;
         rx_seen_q <= 1'b0;
      end
      else if (rx_flash_q && flash_wrap)
      begin
         rx_flash_q <= !rx_seen_q;
         rx_seen_q <= !rx_seen_q;
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   logic test_q;
   logic [lamp_pkg::EVT_W-1:0] evt_q;
   logic [lamp_pkg::EVT_W-1:0] evt_en_q;
   logic [lamp_pkg::EVT_W-1:0] evt_set;
   logic [lamp_pkg::EVT_W-1:0] evt_clr;
   logic bus_off_prev_q;
   logic link_up_prev_q;
   logic [NP-1:0] plink_prev_q;
   logic [lamp_pkg::LAMPS_W-1:0] lamps;

   always_comb
   begin
      evt_set = '0;
      evt_set[lamp_pkg::EVT_RX_ERR] = rx_error;
      evt_set[lamp_pkg::EVT_BUS_OFF] = bus_off && !bus_off_prev_q;
      evt_set[lamp_pkg::EVT_LINK_LOST] = link_up_prev_q && (card_link_state == lamp_pkg::LINK_DOWN);
      evt_set[lamp_pkg::EVT_PORT_CHG] = |(pin_q[NP-1:0] ^ plink_prev_q);
      evt_clr = '0;
      if (wr_stb && addr == lamp_pkg::OFS_EVT_CLR)
      begin
         evt_clr = wr_data[lamp_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         bus_off_prev_q <= 1'b0;
         link_up_prev_q <= 1'b0;
         plink_prev_q <= '0;
      end
      else
      begin
         bus_off_prev_q <= bus_off;
         link_up_prev_q <= (card_link_state == lamp_pkg::LINK_UP);
         plink_prev_q <= pin_q[NP-1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         evt_q <= '0;
      end
      else
      begin
         evt_q <= (evt_q & ~evt_clr) | evt_set;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         test_q <= 1'b0;
         evt_en_q <= '0;
      end
      else if (wr_stb && addr == lamp_pkg::OFS_CTRL)
      begin
         test_q <= wr_data[lamp_pkg::CTRL_TEST_BIT];
      end
      else if (wr_stb && addr == lamp_pkg::OFS_EVT_EN)
      begin
         evt_en_q <= wr_data[lamp_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(((evt_q & ~evt_clr) | evt_set) & evt_en_q);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b || !rd_stb)
      begin
         rd_data <= '0;
      end
      else
      begin
         case (addr)
            lamp_pkg::OFS_CTRL: rd_data <= lamp_pkg::DW'(test_q);
            lamp_pkg::OFS_EVT_STAT: rd_data <= lamp_pkg::DW'(evt_q);
            lamp_pkg::OFS_EVT_EN: rd_data <= lamp_pkg::DW'(evt_en_q);
            lamp_pkg::OFS_LAMPS: rd_data <= lamp_pkg::DW'(lamps);
            default: rd_data <= '0;
         endcase
      end
   end

   // ***************************************************
   // lamp decode
   // ***************************************************
   logic card_d;
   logic run_d;
   logic err_d;
   logic bus_d;
   logic ready_d;

   always_comb
   begin
      case (card_link_state)
         lamp_pkg::LINK_OPENING: card_d = 1'b1;
         lamp_pkg::LINK_UP: card_d = link_phase_q;
         default: card_d = 1'b0;
      endcase
      if (node_fault)
      begin
         run_d = 1'b0;
      end
      else
      begin
         case (node_state)
            lamp_pkg::NODE_OPER: run_d = 1'b1;
            lamp_pkg::NODE_PREOP: run_d = fast_phase_q;
            lamp_pkg::NODE_STOP: run_d = flash_lit;
            default: run_d = 1'b0;
         endcase
      end
      if (bus_off || drive_fault)
      begin
         err_d = 1'b1;
      end
      else if (addr_invalid)
      begin
         err_d = fast_phase_q;
      end
      else if (rx_seen_q)
      begin
         err_d = flash_lit;
      end
      else
      begin
         err_d = 1'b0;
      end
      if (!net_link)
      begin
         bus_d = 1'b1;
      end
      else
      begin
         bus_d = !net_comm_up && fast_phase_q;
      end
      case (stack_state)
         lamp_pkg::STACK_RUN: ready_d = 1'b1;
         lamp_pkg::STACK_WAIT: ready_d = fast_phase_q;
         default: ready_d = 1'b0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         card_link_lamp <= 1'b0;
         node_run_lamp <= 1'b0;
         node_error_lamp <= 1'b0;
         bus_state_lamp <= 1'b0;
         stack_ready_lamp <= 1'b0;
         port_link_lamp <= '0;
         port_traffic_lamp <= '0;
      end
      else
      begin
         card_link_lamp <= card_d || test_q;
         node_run_lamp <= run_d || test_q;
         node_error_lamp <= err_d || test_q;
         bus_state_lamp <= bus_d || test_q;
         stack_ready_lamp <= ready_d || test_q;
         port_link_lamp <= pin_q[NP-1:0] | {NP{test_q}};
         port_traffic_lamp <= pin_q[2*NP-1:NP] | {NP{test_q}};
      end
   end

   assign lamps = {port_traffic_lamp, port_link_lamp, stack_ready_lamp, bus_state_lamp,
                   node_error_lamp, node_run_lamp, card_link_lamp};

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   a_card_opening: assert property (!test_q && card_link_state == lamp_pkg::LINK_OPENING
      |=> card_link_lamp) else $error("card lamp not lit while connecting");
   a_card_blink: assert property (!test_q && card_link_state == lamp_pkg::LINK_UP
      |=> card_link_lamp == $past(link_phase_q)) else $error("card lamp not blinking");
   a_link_period: assert property ($changed(link_phase_q)
      |-> $past(link_cnt_q) == LINK_LAST) else $error("card blink half period wrong");
   a_card_dark: assert property (!test_q && card_link_state == lamp_pkg::LINK_DOWN
      |=> !card_link_lamp) else $error("card lamp lit while disconnected");
   a_run_oper: assert property (!test_q && !node_fault && node_state == lamp_pkg::NODE_OPER
      |=> node_run_lamp) else $error("run lamp dark while operational");
   a_run_fault: assert property (!test_q && node_fault
      |=> !node_run_lamp) else $error("run lamp lit on fault");
   a_err_lit: assert property (!test_q && (bus_off || drive_fault)
      |=> node_error_lamp) else $error("error lamp dark on bus-off");
   a_err_quiet: assert property (!test_q && !bus_off && !drive_fault && !addr_invalid && !rx_flash_q
      |=> !node_error_lamp) else $error("error lamp lit without error");
   a_rx_hold: assert property (rx_error |=> rx_flash_q [*8]) else $error("receive flash dropped");
   a_bus_dark: assert property (!test_q && net_link && net_comm_up
      |=> !bus_state_lamp) else $error("bus lamp lit while communicating");
   a_fast_period: assert property ($changed(fast_phase_q)
      |-> $past(fast_cnt_q) == FAST_LAST) else $error("fast blink half period wrong");
endmodule : status_lamp_driver

// file: test/lamp_far_side.sv
// far side model: the card's port pins for link and traffic
// assumes the bench asks for pin levels; pins move off the clock grid
`timescale 1ns/1ps
module lamp_far_side (
   input wire logic [lamp_pkg::PORTS-1:0] want_link,
   input wire logic [lamp_pkg::PORTS-1:0] want_traffic,
   output logic [lamp_pkg::PORTS-1:0] port_link,
   output logic [lamp_pkg::PORTS-1:0] port_traffic
);
   // ***************************************************
   // asynchronous pins, skewed away from mclk edges
   // ***************************************************
   assign #3 port_link = want_link;
   assign #5 port_traffic = want_traffic;
endmodule : lamp_far_side

// file: test/status_lamp_driver_tb_top.sv
// bench for the status lamp driver: register tasks and lamp checks
// assumes short timing parameters 8/5/4/12 cycles
`timescale 1ns/1ps
module status_lamp_driver_tb_top;
   localparam int unsigned LH = 8;
   localparam int unsigned FH = 5;
   localparam int unsigned FON = 4;
   localparam int unsigned FOFF = 12;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [31:0] rd_data;
   logic irq;
   logic [1:0] card_link_state = 2'h0;
   logic [1:0] node_state = 2'h3;
   logic node_fault = 1'b0;
   logic bus_off = 1'b0;
   logic drive_fault = 1'b0;
   logic addr_invalid = 1'b0;
   logic rx_error = 1'b0;
   logic net_link = 1'b1;
   logic net_comm_up = 1'b1;
   logic [1:0] stack_state = 2'h0;
   logic [1:0] want_link = 2'h0;
   logic [1:0] want_traffic = 2'h0;
   logic [1:0] port_link;
   logic [1:0] port_traffic;
   logic card_link_lamp;
   logic node_run_lamp;
   logic node_error_lamp;
   logic bus_state_lamp;
   logic stack_ready_lamp;
   logic [1:0] port_link_lamp;
   logic [1:0] port_traffic_lamp;
   logic [8:0] lamps;
   logic [31:0] c;
   int n_mismatch = 0;
   int n_tests = 0;

   assign lamps = {port_traffic_lamp, port_link_lamp, stack_ready_lamp, bus_state_lamp, node_error_lamp,
                   node_run_lamp, card_link_lamp};
   always #4 mclk = ~mclk;

   // ***************************************************
   // instances
   // ***************************************************
   status_lamp_driver #(.LINK_HALF_CYC(LH), .FAST_HALF_CYC(FH), .FLASH_ON_CYC(FON), .FLASH_OFF_CYC(FOFF))
      i_status_lamp_driver (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .card_link_state(card_link_state),
      .node_state(node_state), .node_fault(node_fault), .bus_off(bus_off), .drive_fault(drive_fault),
      .addr_invalid(addr_invalid), .rx_error(rx_error), .net_link(net_link), .net_comm_up(net_comm_up),
      .stack_state(stack_state), .port_link(port_link), .port_traffic(port_traffic),
      .card_link_lamp(card_link_lamp), .node_run_lamp(node_run_lamp), .node_error_lamp(node_error_lamp),
      .bus_state_lamp(bus_state_lamp), .stack_ready_lamp(stack_ready_lamp),
      .port_link_lamp(port_link_lamp), .port_traffic_lamp(port_traffic_lamp));
   lamp_far_side i_lamp_far_side (.want_link(want_link), .want_traffic(want_traffic),
      .port_link(port_link), .port_traffic(port_traffic));

   // ***************************************************
   // tasks
   // ***************************************************
   task results;
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_bit
   task wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wt
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1;
      chk_word(rd_data, exp);
   endtask : rd
   task lit(input int idx, input int n, output logic [31:0] cnt);
      cnt = 0;
      repeat (n)
      begin
         @(posedge mclk);
         #1;
         cnt = cnt + lamps[idx];
      end
   endtask : lit

   // ***************************************************
   // tests
   // ***************************************************
   initial
   begin
      #400000;
      n_mismatch++;
      results();
   end
   initial
   begin
      wt(10);
      chk_word({23'h0, lamps}, 32'h0);
      @(posedge mclk) rst_b <= 1'b1;
      rd(lamp_pkg::OFS_LAMPS, 32'h0);
      wr(lamp_pkg::OFS_EVT_EN, 32'h1);
      @(posedge mclk) rx_error <= 1'b1;
      @(posedge mclk) rx_error <= 1'b0;
      lit(2, 32, c);
      chk_word(c, FON);
      chk_bit(irq, 1'b1);
      rd(lamp_pkg::OFS_EVT_STAT, 32'h1);
      wt(32);
      lit(2, 16, c);
      chk_word(c, 32'h0);
      wr(lamp_pkg::OFS_EVT_CLR, 32'h1);
      wt(2);
      chk_bit(irq, 1'b0);
      rd(8'h20, 32'h0);
      rd(lamp_pkg::OFS_EVT_CLR, 32'h0);
      wr(lamp_pkg::OFS_CTRL, 32'h1);
      wt(2);
      rd(lamp_pkg::OFS_LAMPS, 32'h1FF);
      wr(lamp_pkg::OFS_CTRL, 32'h0);
      @(posedge mclk) card_link_state <= lamp_pkg::LINK_OPENING;
      wt(2);
      chk_bit(card_link_lamp, 1'b1);
      @(posedge mclk) card_link_state <= lamp_pkg::LINK_UP;
      wt(2);
      lit(0, 2 * LH, c);
      chk_word(c, LH);
      @(posedge mclk) card_link_state <= lamp_pkg::LINK_DOWN;
      wt(2);
      chk_bit(card_link_lamp, 1'b0);
      @(posedge mclk) card_link_state <= 2'h3;
      wt(2);
      chk_bit(card_link_lamp, 1'b0);
      rd(lamp_pkg::OFS_EVT_STAT, 32'h4);
      @(posedge mclk) node_state <= lamp_pkg::NODE_OPER;
      wt(2);
      chk_bit(node_run_lamp, 1'b1);
      @(posedge mclk) node_fault <= 1'b1;
      wt(2);
      chk_bit(node_run_lamp, 1'b0);
      @(posedge mclk) node_fault <= 1'b0;
      node_state <= lamp_pkg::NODE_PREOP;
      wt(2);
      lit(1, 2 * FH, c);
      chk_word(c, FH);
      @(posedge mclk) node_state <= lamp_pkg::NODE_STOP;
      wt(2);
      lit(1, FON + FOFF, c);
      chk_word(c, FON);
      @(posedge mclk) addr_invalid <= 1'b1;
      wt(2);
      lit(2, 2 * FH, c);
      chk_word(c, FH);
      @(posedge mclk) bus_off <= 1'b1;
      wt(2);
      lit(2, 2 * FH, c);
      chk_word(c, 2 * FH);
      @(posedge mclk) bus_off <= 1'b0;
      drive_fault <= 1'b1;
      wt(2);
      chk_bit(node_error_lamp, 1'b1);
      @(posedge mclk) drive_fault <= 1'b0;
      addr_invalid <= 1'b0;
      wt(2);
      chk_bit(irq, 1'b0);
      rd(lamp_pkg::OFS_EVT_STAT, 32'h6);
      lit(2, 16, c);
      chk_word(c, 32'h0);
      @(posedge mclk) net_link <= 1'b0;
      wt(2);
      chk_bit(bus_state_lamp, 1'b1);
      @(posedge mclk) net_link <= 1'b1;
      net_comm_up <= 1'b0;
      wt(2);
      lit(3, 2 * FH, c);
      chk_word(c, FH);
      @(posedge mclk) net_comm_up <= 1'b1;
      wt(2);
      chk_bit(bus_state_lamp, 1'b0);
      chk_bit(stack_ready_lamp, 1'b0);
      @(posedge mclk) stack_state <= lamp_pkg::STACK_WAIT;
      wt(2);
      lit(4, 2 * FH, c);
      chk_word(c, FH);
      @(posedge mclk) stack_state <= lamp_pkg::STACK_RUN;
      wt(2);
      chk_bit(stack_ready_lamp, 1'b1);
      @(posedge mclk) stack_state <= 2'h3;
      wt(2);
      chk_bit(stack_ready_lamp, 1'b0);
      @(posedge mclk) want_link <= 2'h1;
      want_traffic <= 2'h2;
      wt(8);
      chk_word({30'h0, port_link_lamp}, 32'h1);
      chk_word({30'h0, port_traffic_lamp}, 32'h2);
      @(posedge mclk) want_link <= 2'h2;
      want_traffic <= 2'h0;
      wt(8);
      chk_word({30'h0, port_link_lamp}, 32'h2);
      chk_word({30'h0, port_traffic_lamp}, 32'h0);
      rd(lamp_pkg::OFS_EVT_STAT, 32'hE);
      wr(lamp_pkg::OFS_EVT_EN, 32'h8);
      wt(2);
      chk_bit(irq, 1'b1);
      rd(lamp_pkg::OFS_EVT_EN, 32'h8);
      wt(1);
      chk_word(rd_data, 32'h0);
      @(posedge mclk)
      begin
         addr <= lamp_pkg::OFS_EVT_CLR;
         wr_data <= 32'h9;
         wr_stb <= 1'b1;
         rx_error <= 1'b1;
      end
      @(posedge mclk)
      begin
         wr_stb <= 1'b0;
         rx_error <= 1'b0;
      end
      rd(lamp_pkg::OFS_EVT_STAT, 32'h7);
      chk_bit(irq, 1'b0);
      results();
   end
endmodule : status_lamp_driver_tb_top
